// file: logic/sfi_pkg.sv
/*
 * Package for the serial flash interface state sequencer: state and format
 * enumerations, instruction codes, timing constants.
 * Assumes a 10 MHz system clock; the serial link is sampled, not clocked.
 */
package sfi_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned CLK_NS = NS_PER_S / CLK_HZ;
  // reset timing in ns
  localparam int unsigned RESET_PULSE_NS = 200;
  localparam int unsigned RESET_PROCESS_NS = 35000;
  localparam int unsigned RESET_HOLD_NS = 50;
  localparam int unsigned POWER_UP_NS = 300000;
  // least times round up
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESET_PROCESS_CYC = (RESET_PROCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned POWER_UP_CYC = (POWER_UP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned INSTR_BITS = 8;
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned MODE_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned DATA_W = 8;
  // instruction codes
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_OUT = 8'h3B;
  localparam logic [7:0] CMD_QUAD_OUT = 8'h6B;
  localparam logic [7:0] CMD_DUAL_IO = 8'hBB;
  localparam logic [7:0] CMD_QUAD_IO = 8'hEB;
  localparam logic [7:0] CMD_DDR_QUAD_IO = 8'hED;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71;
  localparam logic [7:0] CMD_WRITE_LEARN = 8'h43;
  localparam logic [7:0] CMD_PROG_LEARN = 8'h42;

  typedef enum logic [1:0] {SFI_W1, SFI_W2, SFI_W4} sfi_width_t;

  typedef enum {
    SFI_POWER_UP, SFI_HW_RESET, SFI_STANDBY, SFI_INSTR, SFI_ADDR_IN,
    SFI_LATENCY, SFI_OUTPUT, SFI_DATA_IN, SFI_IGNORE
  } sfi_state_t;
endpackage

// file: logic/sfi_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock domain; width and depth shape the storage.
 */
module sfi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out = mem_q[rp_q];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sfi_fifo

// file: logic/sfi_core.sv
/*
 * Serial flash interface state sequencer, device side.
 * Assumes serial pins arrive asynchronously and are oversampled by a
 * 10 MHz clock; the link clock must be far slower than the system clock.
 * Read data comes from a user stream through a 4-word FIFO.
 */
// Functional notes
// - chip select high keeps interface in standby
// - single lane instruction, msb first, eight bits
// - write protect sampled only for register writes
// - instruction picks address and transfer format
// - four lane mode takes instruction nibbles
// - output lane undriven during single input cycles
// - next state after input follows the instruction
// - latency count from four bit code
// - latency cycles discard inputs, drive nothing
// - single output drives data, ignores inputs
// - output continues until chip select rises
// - dual input samples lanes zero and one
// - zero latency skips straight to output
// - lane three may act as reset input
// - reset after pulse, standby after process, hold
// - power-up window: no response, no drive
// - quad latency lanes ignored and undriven
// - lane zero carries group least significant bit
// - first data launched on closing falling edge
// - non-read command off byte boundary rejected
module sfi_core
  import sfi_pkg::*;
#(
  parameter int unsigned RESET_PROCESS_CYCLES = RESET_PROCESS_CYC,
  parameter int unsigned POWER_UP_CYCLES = POWER_UP_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clock_in,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe_out,
  input wire logic write_protect_n_in,
  input wire logic hw_reset_n_in,
  input wire logic quad_enable_bit_in,
  input wire logic four_lane_cmd_mode_bit_in,
  input wire logic lane3_reset_enable_in,
  input wire logic [3:0] latency_code_field_in,
  input wire logic [DATA_W-1:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic rd_ready_out,
  output logic [7:0] cmd_out,
  output logic [ADDR_BITS-1:0] addr_out,
  output logic cmd_valid_out,
  output logic cmd_rejected_out,
  output logic [7:0] wr_data_out,
  output logic wr_valid_out,
  output logic wp_blocked_out,
  output logic busy_out
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic sck_prev_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 8'hFF;
      sync2_q <= 8'hFF;
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q <= {hw_reset_n_in, write_protect_n_in, serial_clock_in, chip_select_n_in,
                  lane_in};
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q[5];
    end
  end
  logic [3:0] lanes;
  logic cs_n;
  logic sck;
  logic wp_n;
  logic rst_pin_n;
  assign lanes = sync2_q[3:0];
  assign cs_n = sync2_q[4];
  assign sck = sync2_q[5];
  assign wp_n = sync2_q[6];
  assign rst_pin_n = sync2_q[7];
  logic sck_rise;
  logic sck_fall;
  assign sck_rise = sck && !sck_prev_q;
  assign sck_fall = !sck && sck_prev_q;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic is_read(input logic [7:0] c);
    return c inside {CMD_READ, CMD_FAST_READ, CMD_DUAL_OUT, CMD_QUAD_OUT, CMD_DUAL_IO,
                     CMD_QUAD_IO, CMD_DDR_QUAD_IO};
  endfunction
  function automatic logic is_reg_write(input logic [7:0] c);
    return c inside {CMD_WRITE_STATUS, CMD_WRITE_ANY_REG, CMD_WRITE_LEARN, CMD_PROG_LEARN};
  endfunction
  // register writes without an address go straight to their data bytes
  function automatic logic has_addr(input logic [7:0] c);
    return !(c inside {CMD_WRITE_STATUS, CMD_WRITE_LEARN, CMD_PROG_LEARN});
  endfunction
  // address width per instruction; instruction lanes in four lane mode
  function automatic sfi_width_t addr_width(input logic [7:0] c, input logic four_lane_command_mode);
    if (four_lane_command_mode || c == CMD_QUAD_IO || c == CMD_DDR_QUAD_IO) return SFI_W4;
    if (c == CMD_DUAL_IO) return SFI_W2;
    return SFI_W1;
  endfunction
  function automatic sfi_width_t data_width(input logic [7:0] c, input logic four_lane_command_mode);
    if (four_lane_command_mode || c inside {CMD_QUAD_OUT, CMD_QUAD_IO, CMD_DDR_QUAD_IO}) return SFI_W4;
    if (c inside {CMD_DUAL_OUT, CMD_DUAL_IO}) return SFI_W2;
    return SFI_W1;
  endfunction
  function automatic logic [2:0] step(input sfi_width_t w);
    return (w == SFI_W4) ? 3'd4 : (w == SFI_W2) ? 3'd2 : 3'd1;
  endfunction

  // ****************************************
  // hardware reset and power-up timing
  // ****************************************
  logic quad_mode;
  logic reset_req_n;
  assign quad_mode = quad_enable_bit_in || four_lane_cmd_mode_bit_in;
  // lane three counts only when enabled and not busy carrying quad data
  assign reset_req_n = rst_pin_n && !(lane3_reset_enable_in && !lanes[3]
                       && (!quad_mode || cs_n));
  logic [15:0] pulse_cnt_q;
  logic [18:0] wait_cnt_q;
  logic [15:0] hold_cnt_q;
  sfi_state_t state_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_cnt_q <= '0;
      hold_cnt_q <= '0;
    end else begin
      pulse_cnt_q <= reset_req_n ? '0 : (pulse_cnt_q == 16'hFFFF ? pulse_cnt_q
                     : pulse_cnt_q + 16'h0001);
      hold_cnt_q <= !reset_req_n ? '0 : (hold_cnt_q == 16'hFFFF ? hold_cnt_q
                    : hold_cnt_q + 16'h0001);
    end
  end
  logic reset_start;
  assign reset_start = (pulse_cnt_q == 16'(RESET_PULSE_CYC - 1)) && !reset_req_n;

  // ****************************************
  // main sequencer
  // ****************************************
  logic [7:0] cmd_q;
  logic [ADDR_BITS+MODE_BITS-1:0] shift_q;
  logic [7:0] bit_cnt_q;
  logic [3:0] lat_cnt_q;
  logic [7:0] out_byte_q;
  logic [2:0] out_idx_q;
  logic [3:0] lane_q;
  logic [3:0] oe_q;
  logic launch_q;
  logic [7:0] total_bits_q;
  sfi_width_t w_q;
  logic [7:0] addr_len;
  assign addr_len = (cmd_q inside {CMD_DUAL_IO, CMD_QUAD_IO, CMD_DDR_QUAD_IO}) ?
                    8'(ADDR_BITS + MODE_BITS) : 8'(ADDR_BITS);
  logic [3:0] in_bits;
  assign in_bits = (w_q == SFI_W4) ? lanes : (w_q == SFI_W2) ? {2'b00, lanes[1:0]}
                   : {3'b000, lanes[0]};
  logic [7:0] instr_word;
  assign instr_word = (w_q == SFI_W4) ? {shift_q[3:0], lanes} : {shift_q[6:0], lanes[0]};
  logic [ADDR_BITS+MODE_BITS-1:0] shift_next;
  assign shift_next = (shift_q << step(w_q)) | (ADDR_BITS+MODE_BITS)'(in_bits);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= SFI_POWER_UP;
      wait_cnt_q <= '0;
      cmd_q <= '0;
      shift_q <= '0;
      bit_cnt_q <= '0;
      lat_cnt_q <= '0;
      total_bits_q <= '0;
      w_q <= SFI_W1;
      cmd_valid_out <= 1'b0;
      cmd_rejected_out <= 1'b0;
      wr_valid_out <= 1'b0;
      wr_data_out <= '0;
      wp_blocked_out <= 1'b0;
      addr_out <= '0;
      cmd_out <= '0;
    end else begin
      cmd_valid_out <= 1'b0;
      cmd_rejected_out <= 1'b0;
      wr_valid_out <= 1'b0;
      if (reset_start && state_q != SFI_POWER_UP) begin
        state_q <= SFI_HW_RESET;
        wait_cnt_q <= '0;
      end else begin
        case (state_q)
          SFI_POWER_UP: begin
            wait_cnt_q <= wait_cnt_q + 19'd1;
            if (wait_cnt_q >= 19'(POWER_UP_CYCLES - 1)) begin
              state_q <= SFI_STANDBY;
            end
          end
          SFI_HW_RESET: begin
            if (wait_cnt_q < 19'(RESET_PROCESS_CYCLES)) begin
              wait_cnt_q <= wait_cnt_q + 19'd1;
            end else if (hold_cnt_q >= 16'(RESET_HOLD_CYC)) begin
              state_q <= SFI_STANDBY;
            end
          end
          SFI_STANDBY: begin
            if (!cs_n) begin
              state_q <= SFI_INSTR;
              bit_cnt_q <= '0;
              total_bits_q <= '0;
              w_q <= four_lane_cmd_mode_bit_in ? SFI_W4 : SFI_W1;
              wp_blocked_out <= 1'b0;
            end
          end
          default: begin
            if (cs_n) begin
              state_q <= SFI_STANDBY;
              if (state_q == SFI_DATA_IN || (state_q == SFI_ADDR_IN && !is_read(cmd_q))) begin
                if (total_bits_q[2:0] != 3'd0) begin
                  cmd_rejected_out <= 1'b1;
                end else begin
                  cmd_valid_out <= 1'b1;
                end
              end
            end else if (sck_rise) begin
              total_bits_q <= total_bits_q + 8'(step(w_q));
              case (state_q)
                SFI_INSTR: begin
                  if (bit_cnt_q + 8'(step(w_q)) >= 8'(INSTR_BITS)) begin
                    cmd_q <= instr_word;
                    cmd_out <= instr_word;
                    state_q <= has_addr(instr_word) ? SFI_ADDR_IN : SFI_DATA_IN;
                    bit_cnt_q <= '0;
                    shift_q <= '0;
                    if (is_reg_write(instr_word)) begin
                      wp_blocked_out <= !wp_n;
                    end
                    w_q <= addr_width(instr_word, four_lane_cmd_mode_bit_in);
                  end else begin
                    shift_q <= shift_next;
                    bit_cnt_q <= bit_cnt_q + 8'(step(w_q));
                  end
                end
                SFI_ADDR_IN: begin
                  shift_q <= shift_next;
                  bit_cnt_q <= bit_cnt_q + 8'(step(w_q));
                  if (bit_cnt_q + 8'(step(w_q)) >= addr_len) begin
                    bit_cnt_q <= '0;
                    if (!is_read(cmd_q)) begin
                      state_q <= SFI_DATA_IN;
                    end else begin
                      // the address leads the mode bits when both are sent
                      addr_out <= (addr_len == 8'(ADDR_BITS))
                        ? shift_next[ADDR_BITS-1:0]
                        : shift_next[ADDR_BITS+MODE_BITS-1 -: ADDR_BITS];
                      cmd_valid_out <= 1'b1;
                      lat_cnt_q <= latency_code_field_in;
                      w_q <= data_width(cmd_q, four_lane_cmd_mode_bit_in);
                      state_q <= (cmd_q == CMD_READ || latency_code_field_in == 4'h0)
                                 ? SFI_OUTPUT : SFI_LATENCY;
                    end
                  end
                end
                SFI_DATA_IN: begin
                  shift_q <= shift_next;
                  bit_cnt_q <= bit_cnt_q + 8'(step(w_q));
                  if (bit_cnt_q + 8'(step(w_q)) >= 8'd8) begin
                    bit_cnt_q <= '0;
                    wr_data_out <= shift_next[7:0];
                    wr_valid_out <= 1'b1;
                  end
                end
                SFI_LATENCY: begin
                  // lane values are discarded here
                  lat_cnt_q <= lat_cnt_q - 4'h1;
                  if (lat_cnt_q == 4'h1) begin
                    state_q <= SFI_OUTPUT;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // read data path
  // ****************************************
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic take;
  sfi_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(rd_data_in),
    .wr_valid_in(rd_valid_in),
    .wr_ready_out(rd_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(take)
  );
  logic out_active;
  assign out_active = (state_q == SFI_OUTPUT) && !cs_n;
  // a byte boundary pulls the next word; an empty FIFO repeats the last byte
  assign take = out_active && sck_fall && (out_idx_q == 3'd0);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_byte_q <= '0;
      out_idx_q <= '0;
      lane_q <= '0;
      oe_q <= '0;
      launch_q <= 1'b0;
    end else if (!out_active) begin
      oe_q <= '0;
      out_idx_q <= '0;
      launch_q <= 1'b0;
    end else if (sck_fall) begin
      launch_q <= 1'b1;
      begin : shift_out
        logic [7:0] b;
        b = (out_idx_q == 3'd0) ? (fifo_valid ? fifo_data : out_byte_q) : out_byte_q;
        case (w_q)
          SFI_W4: begin
            lane_q <= (out_idx_q == 3'd0) ? b[7:4] : b[3:0];
            oe_q <= 4'hF;
            out_idx_q <= (out_idx_q == 3'd0) ? 3'd4 : 3'd0;
          end
          SFI_W2: begin
            lane_q <= {2'b00, b[3'd7 - out_idx_q -: 2]};
            oe_q <= 4'h3;
            out_idx_q <= out_idx_q + 3'd2;
          end
          default: begin
            lane_q <= {2'b00, b[3'd7 - out_idx_q], 1'b0};
            oe_q <= 4'h2;
            out_idx_q <= out_idx_q + 3'd1;
          end
        endcase
        out_byte_q <= b;
      end
    end
  end
  // cs rise drops the enables combinationally in the same cycle
  assign lane_oe_out = cs_n ? 4'h0 : oe_q;
  assign lane_out = lane_q;
  assign busy_out = (state_q != SFI_STANDBY);

  // ****************************************
  // checks
  // ****************************************
  chk_standby_no_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cs_n |=> oe_q == 4'h0) else $error("lanes driven with chip select high");
  chk_standby_entry: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == SFI_STANDBY && !cs_n && !reset_start) |=> state_q == SFI_INSTR)
    else $error("no instruction state after select");
  chk_instr_abort: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q == SFI_INSTR && cs_n && !reset_start) |=> state_q == SFI_STANDBY)
    else $error("partial instruction kept");
  chk_no_drive_input: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state_q inside {SFI_INSTR, SFI_ADDR_IN, SFI_LATENCY}) |-> lane_oe_out == 4'h0)
    else $error("lanes driven outside output");
  chk_powerup_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == SFI_POWER_UP |-> lane_oe_out == 4'h0 && !cmd_valid_out)
    else $error("activity in power-up window");
  chk_reset_entry: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (reset_start && state_q != SFI_POWER_UP) |=> state_q == SFI_HW_RESET)
    else $error("reset pulse not honoured");
  chk_zero_latency: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == SFI_LATENCY |-> lat_cnt_q != 4'h0)
    else $error("latency state with zero count");
  chk_launch_fall: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ($rose(launch_q)) |-> $past(sck_fall) && state_q == SFI_OUTPUT)
    else $error("first data not on falling edge");
  chk_reject_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_rejected_out |-> !cmd_valid_out ##1 state_q != SFI_DATA_IN)
    else $error("rejected command also accepted");
  cov_read: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == SFI_LATENCY ##[1:400] state_q == SFI_OUTPUT);
  cov_reject: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_rejected_out);
  cov_hw_reset: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == SFI_HW_RESET);
endmodule // sfi_core

// file: verif/sfi_host_model.sv
/*
 * Host side model of the serial flash link: chip select, serial clock and
 * lane drive, with a bus-level resolver for the shared lanes.
 * Assumes the device's 10 MHz clock; link half period is 4 such cycles.
 */
module sfi_host_model (
  input wire logic ref_clk_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe_out,
  output logic chip_select_n_out,
  output logic serial_clock_out,
  output logic [3:0] lane_in_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] host_q;
  logic [3:0] drive_q;
  logic [3:0] last_q;
  // ****************
  // lane resolution
  // ****************
  // a released lane shows a changing level so stale data cannot pass
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane_in_out[i] = lane_oe_out[i] ? lane_out[i] : (drive_q[i] ? host_q[i] : ~last_q[i]);
  end
  always @(posedge ref_clk_in) begin
    last_q <= lane_in_out;
  end
  initial begin
    chip_select_n_out = 1'b1;
    serial_clock_out = 1'b0;
    host_q = 4'h8;
    drive_q = 4'h8;
    last_q = 4'h0;
  end
  // ****************
  // link tasks
  // ****************
  task automatic half();
    repeat (4) @(posedge ref_clk_in);
    #5;
  endtask
  task automatic start();
    half();
    chip_select_n_out = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      drive_q = 4'h9;
      host_q = {3'b100, v[i]};
      half();
      serial_clock_out = 1'b1;
      half();
      serial_clock_out = 1'b0;
    end
  endtask
  task automatic recv(input int n, output logic [31:0] v);
    drive_q = 4'h8;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      half();
      serial_clock_out = 1'b1;
      half();
      v = {v[30:0], lane_in_out[1]};
      serial_clock_out = 1'b0;
    end
  endtask
  task automatic stop();
    half();
    chip_select_n_out = 1'b1;
    drive_q = 4'h8;
    half();
  endtask
endmodule // sfi_host_model

// file: verif/sfi_core_bench.sv
/*
 * Self-checking bench for the interface sequencer: writes, rejects,
 * partial instructions, a plain read through the FIFO and a pin reset.
 * Assumes shortened power-up and reset process counts of 20 cycles.
 */
module sfi_core_bench;
  import sfi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n, sck, hw_reset_n = 1'b1, rd_valid = 1'b0, rd_ready, cmd_valid, cmd_rej;
  logic wr_valid, wp_blocked, busy;
  logic wp_n = 1'b1;
  logic [3:0] lat_code = 4'h0;
  logic [3:0] lane_in, lane_out, lane_oe;
  logic [7:0] rd_data = 8'h00, cmd, wr_data, last_wr;
  logic [ADDR_BITS-1:0] addr;
  logic [31:0] v;
  int mismatches = 0, tests_run = 0, n_valid = 0, n_rej = 0, n0, r0, k;
  initial forever #50 ref_clk_in = ~ref_clk_in;
  sfi_core #(.RESET_PROCESS_CYCLES(20), .POWER_UP_CYCLES(20)) i_sfi_core (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(cs_n),
    .serial_clock_in(sck), .lane_in(lane_in), .lane_out(lane_out), .lane_oe_out(lane_oe),
    .write_protect_n_in(wp_n), .hw_reset_n_in(hw_reset_n), .quad_enable_bit_in(1'b0),
    .four_lane_cmd_mode_bit_in(1'b0), .lane3_reset_enable_in(1'b0),
    .latency_code_field_in(lat_code), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .rd_ready_out(rd_ready), .cmd_out(cmd), .addr_out(addr), .cmd_valid_out(cmd_valid),
    .cmd_rejected_out(cmd_rej), .wr_data_out(wr_data), .wr_valid_out(wr_valid),
    .wp_blocked_out(wp_blocked), .busy_out(busy));
  sfi_host_model i_sfi_host_model (
    .ref_clk_in(ref_clk_in), .lane_out(lane_out), .lane_oe_out(lane_oe),
    .chip_select_n_out(cs_n), .serial_clock_out(sck), .lane_in_out(lane_in));
  // one-cycle pulses are counted where they stand
  always @(posedge ref_clk_in) begin
    if (cmd_valid === 1'b1) n_valid++;
    if (cmd_rej === 1'b1) n_rej++;
    if (wr_valid === 1'b1) last_wr = wr_data;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge ref_clk_in);
    #5;
    rd_data = d;
    rd_valid = 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk_in);
      if (rd_ready === 1'b1) break;
    end
    #5;
    rd_valid = 1'b0;
    if (k == 20) begin
      check(32'h0, 32'h1);
      stop_test();
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_write();
    n0 = n_valid;
    i_sfi_host_model.start();
    i_sfi_host_model.send(32'h01, 8);
    check(lane_oe, 4'h0);
    i_sfi_host_model.send(32'hA5, 8);
    i_sfi_host_model.stop();
    check(cmd, 8'h01);
    check(last_wr, 8'hA5);
    check(n_valid - n0, 1);
    check(busy, 1'b0);
  endtask
  task automatic t_reject();
    n0 = n_valid;
    r0 = n_rej;
    i_sfi_host_model.start();
    i_sfi_host_model.send(32'h01, 8);
    i_sfi_host_model.send(32'h5, 3);
    i_sfi_host_model.stop();
    check(n_rej - r0, 1);
    check(n_valid - n0, 0);
  endtask
  task automatic t_partial();
    n0 = n_valid;
    r0 = n_rej;
    i_sfi_host_model.start();
    i_sfi_host_model.send(32'h01, 5);
    i_sfi_host_model.stop();
    check(busy, 1'b0);
    check(n_valid - n0 + n_rej - r0, 0);
  endtask
  task automatic t_read();
    push(8'h3C);
    push(8'h5A);
    i_sfi_host_model.start();
    i_sfi_host_model.send(32'h03, 8);
    i_sfi_host_model.send(32'h123456, 24);
    i_sfi_host_model.recv(16, v);
    check(addr, 24'h123456);
    check(v, 32'h3C5A);
    check(lane_oe, 4'h2);
    i_sfi_host_model.stop();
    check(lane_oe, 4'h0);
  endtask
  task automatic t_fast_read();
    wp_n = 1'b0;
    lat_code = 4'h2;
    push(8'h96);
    i_sfi_host_model.start();
    i_sfi_host_model.send(32'h0B, 8);
    i_sfi_host_model.send(32'h000100, 24);
    i_sfi_host_model.recv(1, v);
    check(lane_oe, 4'h0);
    i_sfi_host_model.recv(9, v);
    check(v[7:0], 8'h96);
    check(addr, 24'h000100);
    i_sfi_host_model.stop();
    check(wp_blocked, 1'b0);
    i_sfi_host_model.start();
    i_sfi_host_model.send(32'h015C, 16);
    i_sfi_host_model.stop();
    check(wp_blocked, 1'b1);
    check(last_wr, 8'h5C);
    wp_n = 1'b1;
    lat_code = 4'h0;
  endtask
  task automatic t_reset();
    @(posedge ref_clk_in);
    #5;
    hw_reset_n = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    #5;
    hw_reset_n = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    check(busy, 1'b1);
    for (k = 8; k < 300 && busy !== 1'b0; k++) @(posedge ref_clk_in);
    check(k >= 20 && k < 300, 1'b1);
    if (k >= 300) stop_test();
    t_write();
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_in);
    #5;
    rst_n_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    check(lane_oe, 4'h0);
    repeat (40) @(posedge ref_clk_in);
    t_write();
    t_reject();
    t_partial();
    t_read();
    t_fast_read();
    t_reset();
    stop_test();
  end
endmodule // sfi_core_bench
